// >>> rtl/lsid_defines.svh
// Contract
// - Three immediate loads: 3, 2, 1 cycles
// - Twenty-bit immediate: upper 12 bits zero
// - Eight-bit immediate: upper 24 bits zero
// - Word load: four addressing forms, flags kept
// - Pop general/special: read stack, then add 4
// - Pop status: extra cycle, add 4, flags loaded
// - Half/byte loads zero-extended, three forms
// - Special operand selects one of six registers
// - Word store: four addressing forms, flags kept
// - Push: subtract 4 first, then write
// - Half/byte stores write low 16/8 bits
// - Frame field scaled by access size
// - Frame displacement sign-extended before add
// - Stack field zero-extended, scaled by 4
`ifndef LSID_DEFINES_SVH
`define LSID_DEFINES_SVH
// Opcode bytes of register, stack and long-immediate forms
`define LSID_OP_LD_IND 8'h04
`define LSID_OP_LD_IDX 8'h00
`define LSID_OP_LD_STK 8'h03
`define LSID_OP_LDH_IND 8'h05
`define LSID_OP_LDH_IDX 8'h01
`define LSID_OP_LDB_IND 8'h06
`define LSID_OP_LDB_IDX 8'h02
`define LSID_OP_ST_IND 8'h14
`define LSID_OP_ST_IDX 8'h10
`define LSID_OP_ST_STK 8'h13
`define LSID_OP_STH_IND 8'h15
`define LSID_OP_STH_IDX 8'h11
`define LSID_OP_STB_IND 8'h16
`define LSID_OP_STB_IDX 8'h12
`define LSID_OP_POP 8'h07
`define LSID_OP_PUSH 8'h17
`define LSID_OP_LDI20 8'h9B
`define LSID_OP_LDI32 8'h9F
// Upper nibbles of frame and short-immediate forms
`define LSID_HI_LD_FRM 4'h2
`define LSID_HI_LDH_FRM 4'h4
`define LSID_HI_LDB_FRM 4'h6
`define LSID_HI_ST_FRM 4'h3
`define LSID_HI_STH_FRM 4'h5
`define LSID_HI_STB_FRM 4'h7
`define LSID_HI_LDI8 4'hC
// Sub-codes in bits 7:4
`define LSID_SUB_GPR 4'h0
`define LSID_SUB_SPR 4'h8
`define LSID_SUB_PSR 4'h9
`define LSID_SUB_LDI32 4'h8
// Special register numbers in bits 2:0
`define LSID_SPR_TBR 3'h0
`define LSID_SPR_RP 3'h1
`define LSID_SPR_SSP 3'h2
`define LSID_SPR_USP 3'h3
`define LSID_SPR_MDH 3'h4
`define LSID_SPR_MDL 3'h5
`define LSID_SPR_COUNT 6
// Fixed register numbers, stack step, reset values
`define LSID_IDX_REG 4'hD
`define LSID_FRAME_REG 4'hE
`define LSID_STACK_REG 4'hF
`define LSID_STACK_STEP 32'h00000004
`define LSID_GPR_RESET 32'h00000000
`define LSID_PS_RESET 32'h00000000
// Field positions
`define LSID_FLAGS_MSB 3
`define LSID_FLAGS_LSB 0
`endif

// >>> rtl/lsid_pkg.sv
package lsid_pkg;
    typedef enum logic [1:0] {LSID_SZ_WORD, LSID_SZ_HALF, LSID_SZ_BYTE} lsid_size_t;
    typedef enum logic [2:0] {LSID_AM_IND, LSID_AM_IDX, LSID_AM_FRAME, LSID_AM_STACK,
        LSID_AM_POP, LSID_AM_PUSH} lsid_amode_t;
    typedef enum logic [1:0] {LSID_DST_GPR, LSID_DST_SPR, LSID_DST_PSR} lsid_dst_t;
    // One memory transfer as held while the bus works on it
    typedef struct packed {
        logic we;
        lsid_size_t size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } lsid_mreq_t;
    // Destination of a load
    typedef struct packed {
        lsid_dst_t kind;
        logic [3:0] idx;
        logic pop;
    } lsid_dest_t;
endpackage : lsid_pkg

// >>> rtl/lsid_agu.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsid_defines.svh"
module lsid_agu (
    input wire lsid_pkg::lsid_amode_t mode,
    input wire lsid_pkg::lsid_size_t size,
    input wire logic [31:0] base_rj,
    input wire logic [31:0] idx_reg,
    input wire logic [31:0] frame_reg,
    input wire logic [31:0] stack_reg,
    input wire logic [7:0] disp8,
    input wire logic [3:0] disp4,
    output logic [31:0] addr
);
    logic [31:0] sdisp;
    logic [31:0] frame_off;
    logic [31:0] stack_off;

    // Sign-extend first, then scale by access size
    always_comb begin
        sdisp = {{24{disp8[7]}}, disp8};
        case (size)
            lsid_pkg::LSID_SZ_WORD: frame_off = {sdisp[29:0], 2'b00};
            lsid_pkg::LSID_SZ_HALF: frame_off = {sdisp[30:0], 1'b0};
            default: frame_off = sdisp;
        endcase
        stack_off = {26'h0000000, disp4, 2'b00};
    end

    // Effective address per addressing form
    always_comb begin
        case (mode)
            lsid_pkg::LSID_AM_IND: addr = base_rj;
            lsid_pkg::LSID_AM_IDX: addr = idx_reg + base_rj;
            lsid_pkg::LSID_AM_FRAME: addr = frame_reg + frame_off;
            lsid_pkg::LSID_AM_STACK: addr = stack_reg + stack_off;
            lsid_pkg::LSID_AM_PUSH: addr = stack_reg - `LSID_STACK_STEP;
            default: addr = stack_reg;
        endcase
    end
endmodule : lsid_agu
`default_nettype wire

// >>> rtl/lsid_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsid_defines.svh"
module lsid_top (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [15:0] INSTR,
    input wire logic INSTR_VALID,
    output logic INSTR_READY,
    output logic MEM_REQ,
    output logic MEM_WE,
    output lsid_pkg::lsid_size_t MEM_SIZE,
    output logic [31:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    input wire logic [31:0] MEM_RDATA,
    input wire logic MEM_DONE,
    output logic REG_WR_EN,
    output logic [3:0] REG_WR_IDX,
    output logic [31:0] REG_WR_DATA,
    output logic [3:0] FLAGS,
    output logic [31:0] STACK_PTR
);
    typedef enum {S_IDLE, S_EXT_HI, S_EXT_LO, S_PS_EXTRA, S_MEM} lsid_state_t;

    logic rst_s1_r, rst_s2_r;
    lsid_state_t state_r, state_nxt;
    lsid_pkg::lsid_mreq_t req_r, req_nxt;
    lsid_pkg::lsid_dest_t dst_r, dst_nxt;
    logic [31:0] imm_r, imm_nxt;
    logic is20_r, is20_nxt;
    logic [31:0] gpr_r [16];
    logic [31:0] gpr_nxt [16];
    logic [31:0] spr_r [`LSID_SPR_COUNT];
    logic [31:0] spr_nxt [`LSID_SPR_COUNT];
    logic [31:0] ps_r, ps_nxt;
    logic wr_en, sp_wr;
    logic [3:0] wr_idx;
    logic [31:0] wr_data, sp_data;
    logic wr_en_r;
    logic [3:0] wr_idx_r;
    logic [31:0] wr_data_r;
    logic accept;
    logic [7:0] op;
    logic [3:0] hi, ri, fj;
    logic [2:0] sprn;
    lsid_pkg::lsid_amode_t am;
    lsid_pkg::lsid_size_t sz;
    logic [31:0] agu_addr, ld_val, sp_val, push_data;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    assign op = INSTR[15:8];
    assign hi = INSTR[15:12];
    assign fj = INSTR[7:4];
    assign ri = INSTR[3:0];
    assign sprn = INSTR[2:0];
    assign sp_val = gpr_r[`LSID_STACK_REG];
    assign INSTR_READY = rst_s2_r && (state_r == S_IDLE || state_r == S_EXT_HI || state_r == S_EXT_LO);
    assign accept = INSTR_READY && INSTR_VALID;

    // Addressing form and size from the opcode
    always_comb begin
        am = lsid_pkg::LSID_AM_IND;
        sz = lsid_pkg::LSID_SZ_WORD;
        if (hi == `LSID_HI_LD_FRM || hi == `LSID_HI_ST_FRM || hi == `LSID_HI_LDH_FRM
            || hi == `LSID_HI_STH_FRM || hi == `LSID_HI_LDB_FRM || hi == `LSID_HI_STB_FRM) begin
            am = lsid_pkg::LSID_AM_FRAME;
        end else if (op == `LSID_OP_LD_IDX || op == `LSID_OP_LDH_IDX || op == `LSID_OP_LDB_IDX
            || op == `LSID_OP_ST_IDX || op == `LSID_OP_STH_IDX || op == `LSID_OP_STB_IDX) begin
            am = lsid_pkg::LSID_AM_IDX;
        end else if (op == `LSID_OP_LD_STK || op == `LSID_OP_ST_STK) begin
            am = lsid_pkg::LSID_AM_STACK;
        end else if (op == `LSID_OP_POP) begin
            am = lsid_pkg::LSID_AM_POP;
        end else if (op == `LSID_OP_PUSH) begin
            am = lsid_pkg::LSID_AM_PUSH;
        end
        if (hi == `LSID_HI_LDH_FRM || hi == `LSID_HI_STH_FRM || op == `LSID_OP_LDH_IND
            || op == `LSID_OP_LDH_IDX || op == `LSID_OP_STH_IND || op == `LSID_OP_STH_IDX) begin
            sz = lsid_pkg::LSID_SZ_HALF;
        end else if (hi == `LSID_HI_LDB_FRM || hi == `LSID_HI_STB_FRM || op == `LSID_OP_LDB_IND
            || op == `LSID_OP_LDB_IDX || op == `LSID_OP_STB_IND || op == `LSID_OP_STB_IDX) begin
            sz = lsid_pkg::LSID_SZ_BYTE;
        end
    end

    lsid_agu u_agu (
        .mode(am),
        .size(sz),
        .base_rj(gpr_r[fj]),
        .idx_reg(gpr_r[`LSID_IDX_REG]),
        .frame_reg(gpr_r[`LSID_FRAME_REG]),
        .stack_reg(sp_val),
        .disp8(INSTR[11:4]),
        .disp4(fj),
        .addr(agu_addr)
    );

    // Push source: general, special or status
    always_comb begin
        if (fj == `LSID_SUB_SPR) begin
            push_data = (sprn < 3'(`LSID_SPR_COUNT)) ? spr_r[sprn] : 32'h00000000;
        end else if (fj == `LSID_SUB_PSR) begin
            push_data = ps_r;
        end else begin
            push_data = gpr_r[ri];
        end
    end

    // Zero extension of narrow loads
    always_comb begin
        case (req_r.size)
            lsid_pkg::LSID_SZ_HALF: ld_val = {16'h0000, MEM_RDATA[15:0]};
            lsid_pkg::LSID_SZ_BYTE: ld_val = {24'h000000, MEM_RDATA[7:0]};
            default: ld_val = MEM_RDATA;
        endcase
    end

    // Sequencer: decode, immediate halfwords, memory wait
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        dst_nxt = dst_r;
        imm_nxt = imm_r;
        is20_nxt = is20_r;
        wr_en = 1'b0;
        wr_idx = dst_r.idx;
        wr_data = 32'h00000000;
        sp_wr = 1'b0;
        sp_data = sp_val;
        ps_nxt = ps_r;
        for (int k = 0; k < `LSID_SPR_COUNT; k++) begin
            spr_nxt[k] = spr_r[k];
        end
        case (state_r)
            S_IDLE: begin
                if (accept) begin
                    dst_nxt = '{kind: lsid_pkg::LSID_DST_GPR, idx: ri, pop: 1'b0};
                    req_nxt = '{we: 1'b0, size: sz, addr: agu_addr, wdata: 32'h00000000};
                    if (hi == `LSID_HI_LDI8) begin
                        wr_en = 1'b1;
                        wr_idx = ri;
                        wr_data = {24'h000000, INSTR[11:4]};
                    end else if (op == `LSID_OP_LDI20) begin
                        imm_nxt = {12'h000, fj, 16'h0000};
                        is20_nxt = 1'b1;
                        state_nxt = S_EXT_LO;
                    end else if (op == `LSID_OP_LDI32 && fj == `LSID_SUB_LDI32) begin
                        is20_nxt = 1'b0;
                        state_nxt = S_EXT_HI;
                    end else if (op == `LSID_OP_POP && (fj == `LSID_SUB_GPR || fj == `LSID_SUB_SPR
                        || fj == `LSID_SUB_PSR)) begin
                        dst_nxt.pop = 1'b1;
                        dst_nxt.kind = (fj == `LSID_SUB_SPR) ? lsid_pkg::LSID_DST_SPR
                            : (fj == `LSID_SUB_PSR) ? lsid_pkg::LSID_DST_PSR : lsid_pkg::LSID_DST_GPR;
                        state_nxt = (fj == `LSID_SUB_PSR) ? S_PS_EXTRA : S_MEM;
                    end else if (op == `LSID_OP_PUSH && (fj == `LSID_SUB_GPR || fj == `LSID_SUB_SPR
                        || fj == `LSID_SUB_PSR)) begin
                        req_nxt.we = 1'b1;
                        req_nxt.wdata = push_data;
                        sp_wr = 1'b1;
                        sp_data = agu_addr;
                        state_nxt = S_MEM;
                    end else if (op == `LSID_OP_LD_IND || op == `LSID_OP_LD_IDX || op == `LSID_OP_LD_STK
                        || op == `LSID_OP_LDH_IND || op == `LSID_OP_LDH_IDX || op == `LSID_OP_LDB_IND
                        || op == `LSID_OP_LDB_IDX || hi == `LSID_HI_LD_FRM || hi == `LSID_HI_LDH_FRM
                        || hi == `LSID_HI_LDB_FRM) begin
                        state_nxt = S_MEM;
                    end else if (op == `LSID_OP_ST_IND || op == `LSID_OP_ST_IDX || op == `LSID_OP_ST_STK
                        || op == `LSID_OP_STH_IND || op == `LSID_OP_STH_IDX || op == `LSID_OP_STB_IND
                        || op == `LSID_OP_STB_IDX || hi == `LSID_HI_ST_FRM || hi == `LSID_HI_STH_FRM
                        || hi == `LSID_HI_STB_FRM) begin
                        req_nxt.we = 1'b1;
                        req_nxt.wdata = (sz == lsid_pkg::LSID_SZ_HALF) ? {16'h0000, gpr_r[ri][15:0]}
                            : (sz == lsid_pkg::LSID_SZ_BYTE) ? {24'h000000, gpr_r[ri][7:0]}
                            : gpr_r[ri];
                        state_nxt = S_MEM;
                    end
                end
            end
            S_EXT_HI: begin
                if (accept) begin
                    imm_nxt = {INSTR, 16'h0000};
                    state_nxt = S_EXT_LO;
                end
            end
            S_EXT_LO: begin
                if (accept) begin
                    wr_en = 1'b1;
                    wr_data = {imm_r[31:16], INSTR};
                    state_nxt = S_IDLE;
                end
            end
            S_PS_EXTRA: state_nxt = S_MEM;
            S_MEM: begin
                if (MEM_DONE) begin
                    state_nxt = S_IDLE;
                    if (!req_r.we) begin
                        case (dst_r.kind)
                            lsid_pkg::LSID_DST_SPR: begin
                                if (dst_r.idx[2:0] < 3'(`LSID_SPR_COUNT) && !dst_r.idx[3]) begin
                                    spr_nxt[dst_r.idx[2:0]] = MEM_RDATA;
                                end
                            end
                            lsid_pkg::LSID_DST_PSR: ps_nxt = MEM_RDATA;
                            default: begin
                                wr_en = 1'b1;
                                wr_data = ld_val;
                            end
                        endcase
                        if (dst_r.pop) begin
                            sp_wr = 1'b1;
                            sp_data = sp_val + `LSID_STACK_STEP;
                        end
                    end
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // General registers; stack update wins over a load into the stack register
    for (genvar g = 0; g < 16; g++) begin : g_gpr
        always_comb begin
            if (sp_wr && g == `LSID_STACK_REG) begin
                gpr_nxt[g] = sp_data;
            end else if (wr_en && wr_idx == 4'(g)) begin
                gpr_nxt[g] = wr_data;
            end else begin
                gpr_nxt[g] = gpr_r[g];
            end
        end
        always_ff @(posedge CLK or negedge rst_s2_r) begin
            if (!rst_s2_r) begin
                gpr_r[g] <= `LSID_GPR_RESET;
            end else begin
                gpr_r[g] <= gpr_nxt[g];
            end
        end
    end

    // Sequencer, special and status registers, write trace
    always_ff @(posedge CLK or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            state_r <= S_IDLE;
            req_r <= '{we: 1'b0, size: lsid_pkg::LSID_SZ_WORD, addr: 32'h00000000, wdata: 32'h00000000};
            dst_r <= '{kind: lsid_pkg::LSID_DST_GPR, idx: 4'h0, pop: 1'b0};
            imm_r <= 32'h00000000;
            is20_r <= 1'b0;
            ps_r <= `LSID_PS_RESET;
            for (int k = 0; k < `LSID_SPR_COUNT; k++) begin
                spr_r[k] <= 32'h00000000;
            end
            wr_en_r <= 1'b0;
            wr_idx_r <= 4'h0;
            wr_data_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            dst_r <= dst_nxt;
            imm_r <= imm_nxt;
            is20_r <= is20_nxt;
            ps_r <= ps_nxt;
            for (int k = 0; k < `LSID_SPR_COUNT; k++) begin
                spr_r[k] <= spr_nxt[k];
            end
            wr_en_r <= wr_en;
            wr_idx_r <= wr_idx;
            wr_data_r <= wr_data;
        end
    end

    assign MEM_REQ = (state_r == S_MEM);
    assign MEM_WE = req_r.we;
    assign MEM_SIZE = req_r.size;
    assign MEM_ADDR = req_r.addr;
    assign MEM_WDATA = req_r.wdata;
    assign REG_WR_EN = wr_en_r;
    assign REG_WR_IDX = wr_idx_r;
    assign REG_WR_DATA = wr_data_r;
    assign FLAGS = ps_r[`LSID_FLAGS_MSB:`LSID_FLAGS_LSB];
    assign STACK_PTR = sp_val;

    // Checks
    logic [31:0] exp_stk_addr;
    assign exp_stk_addr = sp_val + {26'h0000000, fj, 2'b00};
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_s2_r);

    ldi8_zero_ext_a: assert property (state_r == S_IDLE && accept && hi == `LSID_HI_LDI8
        |=> REG_WR_EN && REG_WR_DATA[31:8] == 24'h000000 && REG_WR_IDX == $past(ri))
        else $error("short immediate not zero-extended");
    ldi20_zero_ext_a: assert property (state_r == S_EXT_LO && is20_r && accept
        |=> REG_WR_EN && REG_WR_DATA[31:20] == 12'h000)
        else $error("twenty-bit immediate upper bits set");
    ldi32_time_a: assert property (state_r == S_IDLE && accept && op == `LSID_OP_LDI32 && fj == `LSID_SUB_LDI32
        ##1 accept ##1 accept |=> REG_WR_EN && REG_WR_DATA == {$past(INSTR, 2), $past(INSTR)}
        && REG_WR_IDX == $past(ri, 3))
        else $error("long immediate write wrong");
    flags_kept_a: assert property (state_r != S_MEM |=> $stable(FLAGS))
        else $error("flags changed outside a status pop");
    pop_inc_a: assert property (state_r == S_MEM && MEM_DONE && !req_r.we && dst_r.pop
        |=> STACK_PTR == $past(STACK_PTR) + 32'h00000004)
        else $error("pop did not add four");
    ps_pop_time_a: assert property (state_r == S_IDLE && accept && op == `LSID_OP_POP && fj == `LSID_SUB_PSR
        |=> !MEM_REQ ##1 MEM_REQ && MEM_ADDR == STACK_PTR)
        else $error("status pop timing wrong");
    push_dec_a: assert property (state_r == S_IDLE && accept && op == `LSID_OP_PUSH
        && (fj == `LSID_SUB_GPR || fj == `LSID_SUB_SPR || fj == `LSID_SUB_PSR)
        |=> MEM_REQ && MEM_WE && MEM_ADDR == STACK_PTR && STACK_PTR == $past(STACK_PTR) - 32'h00000004)
        else $error("push address wrong");
    stack_disp_a: assert property (state_r == S_IDLE && accept && op == `LSID_OP_LD_STK
        |=> MEM_ADDR == $past(exp_stk_addr))
        else $error("stack displacement wrong");
    byte_zext_a: assert property (MEM_REQ && MEM_DONE && !MEM_WE && MEM_SIZE == lsid_pkg::LSID_SZ_BYTE
        && dst_r.kind == lsid_pkg::LSID_DST_GPR |=> REG_WR_EN && REG_WR_DATA[31:8] == 24'h000000)
        else $error("byte load not zero-extended");
    mem_hold_a: assert property (MEM_REQ && !MEM_DONE |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("request dropped before completion");
    ldi32_cov_c: cover property (state_r == S_EXT_LO && !is20_r && accept);
    ps_pop_cov_c: cover property (state_r == S_PS_EXTRA);
    push_cov_c: cover property (MEM_REQ && MEM_WE && MEM_DONE && dst_r.idx == 4'h0);
    byte_st_cov_c: cover property (MEM_REQ && MEM_WE && MEM_SIZE == lsid_pkg::LSID_SZ_BYTE && MEM_DONE);
endmodule : lsid_top
`default_nettype wire

// >>> verification/lsid_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Data memory behind the load/store bus, answering after a commanded stall
module lsid_mem_model (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic MEM_REQ,
    input wire logic [3:0] dly,
    input wire logic [31:0] rd_value,
    output logic MEM_DONE,
    output logic [31:0] MEM_RDATA
);
    logic [3:0] wait_r;
    logic [3:0] wait_nxt;
    logic [31:0] last_r;
    logic [31:0] last_nxt;
    // Completion after dly stall cycles; data toggles when not valid
    always_comb begin
        MEM_DONE = MEM_REQ && (wait_r == dly);
        wait_nxt = (MEM_REQ && !MEM_DONE) ? wait_r + 4'h1 : 4'h0;
        MEM_RDATA = MEM_DONE ? rd_value : ~last_r; // No stale read data
        last_nxt = MEM_RDATA;
    end
    // Stall count and last bus value
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wait_r <= 4'h0;
            last_r <= 32'h0;
        end else begin
            wait_r <= wait_nxt;
            last_r <= last_nxt;
        end
    end
endmodule : lsid_mem_model
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam lsid_pkg::lsid_size_t SW = lsid_pkg::LSID_SZ_WORD;
    localparam lsid_pkg::lsid_size_t SH = lsid_pkg::LSID_SZ_HALF;
    localparam lsid_pkg::lsid_size_t SB = lsid_pkg::LSID_SZ_BYTE;
    logic clk, arst_n, ivalid, iready, req, we, done, wr_en;
    logic [15:0] instr;
    lsid_pkg::lsid_size_t msize;
    logic [31:0] addr, wdat, rdat, wr_data, sp, rd_value;
    logic [3:0] wr_idx, flags, dly, flags_exp;
    int n_errors, checks_done;
    lsid_top dut_u (.CLK(clk), .ARST_N(arst_n), .INSTR(instr), .INSTR_VALID(ivalid), .INSTR_READY(iready),
        .MEM_REQ(req), .MEM_WE(we), .MEM_SIZE(msize), .MEM_ADDR(addr), .MEM_WDATA(wdat), .MEM_RDATA(rdat),
        .MEM_DONE(done), .REG_WR_EN(wr_en), .REG_WR_IDX(wr_idx), .REG_WR_DATA(wr_data), .FLAGS(flags),
        .STACK_PTR(sp));
    lsid_mem_model mem_u (.CLK(clk), .ARST_N(arst_n), .MEM_REQ(req), .dly(dly), .rd_value(rd_value),
        .MEM_DONE(done), .MEM_RDATA(rdat));
    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Offer one halfword from a falling edge and hold it until taken
    task automatic issue(input logic [15:0] h, input logic last);
        int n;
        if (ivalid !== 1'b1) @(negedge clk); // Let an edge pass after a drop
        instr = h;
        ivalid = 1'b1;
        for (n = 0; n < 20 && iready !== 1'b1; n++) @(negedge clk);
        if (n == 20) begin
            n_errors++;
            complete_run();
        end
        @(negedge clk);
        if (last) ivalid = 1'b0;
    endtask : issue
    task automatic chk_wr(input logic [3:0] idx, input logic [31:0] d);
        check("wr_en", {31'h0, wr_en}, 32'h1);
        check("wr_idx", {28'h0, wr_idx}, {28'h0, idx});
        check("wr_data", wr_data, d);
    endtask : chk_wr
    // One memory instruction; the bus stalls d cycles before completing
    task automatic mem_op(input logic [15:0] op, input logic w, input lsid_pkg::lsid_size_t sz,
        input logic [31:0] a, input logic [31:0] wd, input logic [31:0] rd, input logic [3:0] d, input int lat);
        int n;
        dly = d;
        rd_value = rd;
        issue(op, 1'b1);
        for (n = 1; n < 10 && req !== 1'b1; n++) @(negedge clk);
        if (n == 10) begin
            n_errors++;
            complete_run();
        end
        check("req_latency", n, lat);
        for (n = 0; n < 20 && done !== 1'b1; n++) begin
            check("ready_low", {31'h0, iready}, 32'h0);
            @(negedge clk);
        end
        if (n == 20) begin
            n_errors++;
            complete_run();
        end
        check("we", {31'h0, we}, {31'h0, w});
        check("size", 32'(msize), 32'(sz));
        check("addr", addr, a);
        if (w) check("wdata", wdat, wd);
        @(negedge clk);
        check("req_drop", {31'h0, req}, 32'h0);
        check("flags", {28'h0, flags}, {28'h0, flags_exp});
        if (w) check("no_wr", {31'h0, wr_en}, 32'h0);
    endtask : mem_op
    task automatic ldi32(input logic [3:0] r, input logic [31:0] v);
        issue({12'h9F8, r}, 1'b0);
        issue(v[31:16], 1'b0);
        issue(v[15:0], 1'b1);
        chk_wr(r, v);
    endtask : ldi32
    task automatic scen_imm();
        ldi32(4'hF, 32'h00001000);
        check("sp", sp, 32'h00001000);
        ldi32(4'h1, 32'h12345678);
        ldi32(4'hE, 32'h00000100);
        issue(16'h9BF2, 1'b0);
        issue(16'hBEEF, 1'b1);
        chk_wr(4'h2, 32'h000FBEEF);
        issue(16'hC5A3, 1'b0);
        chk_wr(4'h3, 32'h0000005A);
        issue(16'hCFFD, 1'b1);
        chk_wr(4'hD, 32'h000000FF);
        check("flags", {28'h0, flags}, 32'h0);
        issue(16'h8B12, 1'b1);
        check("ign_wr", {31'h0, wr_en}, 32'h0);
        check("ign_req", {31'h0, req}, 32'h0);
    endtask : scen_imm
    // Index base 0xFF, frame 0x100, stack 0x1000; loaded upper bits are junk
    task automatic scen_load();
        mem_op(16'h0034, 1'b0, SW, 32'h159, 32'h0, 32'hCAFEF00D, 4'h2, 1);
        chk_wr(4'h4, 32'hCAFEF00D);
        mem_op(16'h2FF5, 1'b0, SW, 32'hFC, 32'h0, 32'h11223344, 4'h0, 1);
        chk_wr(4'h5, 32'h11223344);
        mem_op(16'h03F6, 1'b0, SW, 32'h103C, 32'h0, 32'h55667788, 4'h1, 1);
        chk_wr(4'h6, 32'h55667788);
        mem_op(16'h0537, 1'b0, SH, 32'h5A, 32'h0, 32'hFFFF8001, 4'h0, 1);
        chk_wr(4'h7, 32'h00008001);
        mem_op(16'h4FF9, 1'b0, SH, 32'hFE, 32'h0, 32'hABCD1234, 4'h0, 1);
        chk_wr(4'h9, 32'h00001234);
        mem_op(16'h6808, 1'b0, SB, 32'h80, 32'h0, 32'hFFFFFFA5, 4'h0, 1);
        chk_wr(4'h8, 32'h000000A5);
        mem_op(16'h043A, 1'b0, SW, 32'h5A, 32'h0, 32'h01020304, 4'h0, 1);
        chk_wr(4'hA, 32'h01020304);
        mem_op(16'h013B, 1'b0, SH, 32'h159, 32'h0, 32'h7777BEEF, 4'h1, 1);
        chk_wr(4'hB, 32'h0000BEEF);
        mem_op(16'h063C, 1'b0, SB, 32'h5A, 32'h0, 32'h123456C3, 4'h0, 1);
        chk_wr(4'hC, 32'h000000C3);
    endtask : scen_load
    task automatic scen_store();
        mem_op(16'h1431, 1'b1, SW, 32'h5A, 32'h12345678, 32'h0, 4'h3, 1);
        mem_op(16'h5021, 1'b1, SH, 32'h104, 32'h5678, 32'h0, 4'h0, 1);
        mem_op(16'h1231, 1'b1, SB, 32'h159, 32'h78, 32'h0, 4'h1, 1);
        mem_op(16'h1311, 1'b1, SW, 32'h1004, 32'h12345678, 32'h0, 4'h0, 1);
        mem_op(16'h3FE1, 1'b1, SW, 32'hF8, 32'h12345678, 32'h0, 4'h0, 1);
        mem_op(16'h1531, 1'b1, SH, 32'h5A, 32'h5678, 32'h0, 4'h0, 1);
        mem_op(16'h7031, 1'b1, SB, 32'h103, 32'h78, 32'h0, 4'h0, 1);
    endtask : scen_store
    task automatic scen_stack();
        mem_op(16'h1701, 1'b1, SW, 32'hFFC, 32'h12345678, 32'h0, 4'h0, 1);
        check("sp", sp, 32'hFFC);
        mem_op(16'h0702, 1'b0, SW, 32'hFFC, 32'h0, 32'h0BADBEEF, 4'h2, 1);
        chk_wr(4'h2, 32'h0BADBEEF);
        check("sp", sp, 32'h1000);
        flags_exp = 4'hB;
        mem_op(16'h0790, 1'b0, SW, 32'h1000, 32'h0, 32'hFFFFFFFB, 4'h1, 2);
        check("sp", sp, 32'h1004);
        mem_op(16'h1790, 1'b1, SW, 32'h1000, 32'hFFFFFFFB, 32'h0, 4'h0, 1);
        check("sp", sp, 32'h1000);
    endtask : scen_stack
    // Fill all six special registers, then push them back in reverse
    task automatic scen_special();
        int s;
        for (s = 0; s < 6; s++) begin
            mem_op({12'h078, 4'(s)}, 1'b0, SW, 32'(32'h1000 + 4 * s), 32'h0, 32'(32'hA0 + s), 4'h0, 1);
        end
        check("sp", sp, 32'h1018);
        for (s = 5; s >= 0; s--) begin
            mem_op({12'h178, 4'(s)}, 1'b1, SW, 32'(32'h1000 + 4 * s), 32'(32'hA0 + s), 32'h0, 4'h1, 1);
        end
        check("sp", sp, 32'h1000);
        mem_op(16'h1786, 1'b1, SW, 32'hFFC, 32'h0, 32'h0, 4'h0, 1);
        mem_op(16'h0786, 1'b0, SW, 32'hFFC, 32'h0, 32'h0, 4'h0, 1);
        check("sp", sp, 32'h1000);
    endtask : scen_special
    // Reset, then every scenario in turn
    initial begin
        n_errors = 0;
        checks_done = 0;
        flags_exp = 4'h0;
        instr = 16'h0000;
        ivalid = 1'b0;
        dly = 4'h0;
        rd_value = 32'h0;
        arst_n = 1'b0;
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        scen_imm();
        scen_load();
        scen_store();
        scen_stack();
        scen_special();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
